//--- core/interval_channel.sv
// How it works
// - Software strobe mode: output high, low one count clock when counter hits zero.
// - Software strobe mode: writing the count starts the sequence, no gate edge needed.
// - Software strobe mode: gate high counts, gate low pauses, gate never moves output.
// - Software strobe mode: written count loads on next count clock fall without decrement; strobe after N+1.
// - Software strobe mode: a new count restarts counting from next clock fall.
// - Software strobe two-byte count: first byte leaves counting alone; reload after second byte.
// - Hardware strobe mode: after gate trigger and zero, output low one clock.
// - Hardware strobe mode: load on clock after trigger without decrement; strobe N+1 later.
// - Hardware strobe mode: each gate rise retriggers and reloads on next clock fall.
// - Hardware strobe mode: gate only triggers, never drives the output level.
// - Hardware strobe mode: a written count waits for the next gate trigger.
// - Rate and square modes: gate low stops counting and forces output high.
// - One-shot and hardware strobe: gate rise starts and retriggers the sequence.
// - Event and software strobe: gate level only enables counting, edges mean nothing.
// - All counting is downward; square wave mode steps by two.
// - Host reads count directly, by latch command, or by read-back command.
// - Latch command freezes count until read or new control word.
`timescale 1ns/1ps
module interval_channel
    import timer_chan_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    // Host control word and read-back
    input  wire logic       ctrl_wr,
    input  wire logic [2:0] ctrl_mode,
    input  wire logic [1:0] ctrl_rw,
    input  wire logic       rb_count,
    input  wire logic       rb_status,
    // Host count bytes
    input  wire logic       wr_stb,
    input  wire logic [7:0] wr_data,
    input  wire logic       rd_stb,
    output logic      [7:0] rd_data,
    // Counter pins
    input  wire logic       cnt_clk,
    input  wire logic       gate,
    output logic            cnt_out
);
    chan_if ifc ();

    mode_t       mode;
    rw_t         rw;
    logic [15:0] ce;
    logic        out_q;
    logic        running;
    logic        armed;
    logic        null_count;
    logic        load_pend;
    logic        trig_pend;
    logic        have_count;
    logic        suspend;

    mode_t       next_mode;
    rw_t         next_rw;
    logic [15:0] next_ce;
    logic        next_out;
    logic        next_running;
    logic        next_armed;
    logic        next_null;
    logic        next_load_pend;
    logic        next_trig_pend;
    logic        next_have;
    logic        next_suspend;

    logic        clk_fall;
    logic        gate_rise;

    pin_edges u_edges (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .cnt_clk   (cnt_clk),
        .gate      (gate),
        .clk_fall  (clk_fall),
        .gate_rise (gate_rise)
    );

    host_byte_port u_bytes (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .wr_stb    (wr_stb),
        .wr_data   (wr_data),
        .rd_stb    (rd_stb),
        .rb_status (rb_status),
        .rd_data   (rd_data),
        .ifc       (ifc.host_side)
    );

    // Control word decode; codes 6 and 7 act as rate and square
    wire        ctrl_load = ctrl_wr && ctrl_rw != RW_LATCH;
    wire mode_t new_mode  = mode_t'({ctrl_mode[2] & ~ctrl_mode[1], ctrl_mode[1:0]});

    // Mode classes
    wire periodic    = (mode == MODE_RATE) || (mode == MODE_SQUARE);
    wire strobe_mode = (mode == MODE_SW_STROBE) || (mode == MODE_HW_STROBE);
    wire gated_mode  = (mode == MODE_EVENT) || (mode == MODE_SW_STROBE) || periodic;
    wire trig_mode   = (mode == MODE_ONESHOT) || (mode == MODE_HW_STROBE) || periodic;

    // Counting arithmetic
    wire [15:0] step      = (mode == MODE_SQUARE) ? STEP_TWO : STEP_ONE;
    wire [15:0] dec_ce    = ce - step;
    wire [15:0] reload_ce = load_value(ifc.held_cnt, mode);
    wire        sq_term   = (out_q && ifc.held_cnt[0]) ? (ce == CE_ZERO) : (ce == SQUARE_END);

    // Writes that load at once, versus writes that wait for a trigger or terminal count
    wire write_load = (mode == MODE_EVENT) || (mode == MODE_SW_STROBE)
                      || (periodic && !running);
    wire load_now   = clk_fall && have_count
                      && (load_pend || (trig_pend && trig_mode));
    wire count_ok   = running && !suspend && (!gated_mode || gate);

    assign ifc.ce         = ce;
    assign ifc.out_lvl    = out_q;
    assign ifc.null_count = null_count;
    assign ifc.mode       = mode;
    assign ifc.rw         = rw;
    assign ifc.ctrl_load  = ctrl_load;
    assign ifc.latch_req  = (ctrl_wr && ctrl_rw == RW_LATCH) || rb_count;
    assign cnt_out        = out_q;

    always_comb begin
        next_mode      = mode;
        next_rw        = rw;
        next_ce        = ce;
        next_out       = out_q;
        next_running   = running;
        next_armed     = armed;
        next_null      = null_count;
        next_load_pend = load_pend;
        next_trig_pend = trig_pend;
        next_have      = have_count;
        next_suspend   = suspend;
        if (ctrl_load) begin
            next_mode      = new_mode;
            next_rw        = rw_t'(ctrl_rw);
            next_out       = (new_mode != MODE_EVENT);
            next_running   = 1'b0;
            next_armed     = 1'b0;
            next_null      = 1'b1;
            next_load_pend = 1'b0;
            next_trig_pend = 1'b0;
            next_have      = 1'b0;
            next_suspend   = 1'b0;
        end else begin
            if (clk_fall) begin
                // A strobe lasts exactly one count clock
                if (strobe_mode && !out_q) begin
                    next_out = 1'b1;
                end
                next_trig_pend = 1'b0;
                if (load_now) begin
                    next_ce        = reload_ce;
                    next_running   = 1'b1;
                    next_armed     = 1'b1;
                    next_null      = 1'b0;
                    next_load_pend = 1'b0;
                    if (mode == MODE_ONESHOT) begin
                        next_out = 1'b0;
                    end
                    if (mode == MODE_SQUARE && !running) begin
                        next_out = 1'b1;
                    end
                end else if (count_ok) begin
                    case (mode)
                        MODE_RATE: begin
                            if (ce == RATE_END) begin
                                next_ce   = reload_ce;
                                next_null = 1'b0;
                                next_out  = 1'b1;
                            end else begin
                                next_ce  = dec_ce;
                                next_out = (dec_ce != RATE_END);
                            end
                        end
                        MODE_SQUARE: begin
                            if (sq_term) begin
                                next_ce   = reload_ce;
                                next_null = 1'b0;
                                next_out  = !out_q;
                            end else begin
                                next_ce = dec_ce;
                            end
                        end
                        MODE_SW_STROBE, MODE_HW_STROBE: begin
                            next_ce = dec_ce;
                            if (armed && dec_ce == CE_ZERO) begin
                                next_out   = 1'b0;
                                next_armed = 1'b0;
                            end
                        end
                        default: begin
                            next_ce = dec_ce;
                            if (dec_ce == CE_ZERO) begin
                                next_out = 1'b1;
                            end
                        end
                    endcase
                end
            end
            // Gate rise latches a trigger; a rise on the consuming cycle survives
            if (gate_rise && trig_mode) begin
                next_trig_pend = 1'b1;
            end
            // First of two bytes: event counting pauses, other modes ignore it
            if (ifc.first_done && mode == MODE_EVENT) begin
                next_suspend = 1'b1;
                next_out     = 1'b0;
            end
            if (ifc.count_done) begin
                next_null    = 1'b1;
                next_have    = 1'b1;
                next_suspend = 1'b0;
                if (write_load) begin
                    next_load_pend = 1'b1;
                end
                if (mode == MODE_EVENT) begin
                    next_out = 1'b0;
                end
            end
            if (periodic && !gate) begin
                next_out = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode       <= MODE_RESET;
            rw         <= RW_RESET;
            ce         <= CE_RESET;
            out_q      <= OUT_RESET;
            running    <= 1'b0;
            armed      <= 1'b0;
            null_count <= 1'b1;
            load_pend  <= 1'b0;
            trig_pend  <= 1'b0;
            have_count <= 1'b0;
            suspend    <= 1'b0;
        end else begin
            mode       <= next_mode;
            rw         <= next_rw;
            ce         <= next_ce;
            out_q      <= next_out;
            running    <= next_running;
            armed      <= next_armed;
            null_count <= next_null;
            load_pend  <= next_load_pend;
            trig_pend  <= next_trig_pend;
            have_count <= next_have;
            suspend    <= next_suspend;
        end
    end

    property p_strobe_one_clk;
        @(posedge core_clk) disable iff (!arst_n)
        strobe_mode && !out_q && clk_fall && !ctrl_load |=> out_q;
    endproperty
    a_strobe_one_clk: assert property (p_strobe_one_clk) else $error("strobe too long");

    property p_out_on_clk;
        @(posedge core_clk) disable iff (!arst_n)
        strobe_mode && $changed(out_q) && !$past(ctrl_load) |-> $past(clk_fall);
    endproperty
    a_out_on_clk: assert property (p_out_on_clk) else $error("output moved off clock");

    property p_sw_write_loads;
        @(posedge core_clk) disable iff (!arst_n)
        mode == MODE_SW_STROBE && ifc.count_done && !ctrl_load |=> load_pend;
    endproperty
    a_sw_write_loads: assert property (p_sw_write_loads) else $error("write did not arm");

    property p_load_no_dec;
        @(posedge core_clk) disable iff (!arst_n)
        load_now && !ctrl_load && mode != MODE_SQUARE |=> ce == $past(ifc.held_cnt);
    endproperty
    a_load_no_dec: assert property (p_load_no_dec) else $error("load value wrong");

    property p_restart;
        @(posedge core_clk) disable iff (!arst_n)
        mode == MODE_SW_STROBE && load_now && !ctrl_load |=> armed && running;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart on reload");

    property p_first_byte;
        @(posedge core_clk) disable iff (!arst_n)
        mode == MODE_SW_STROBE && ifc.first_done && !load_pend && !ctrl_load |=> !load_pend;
    endproperty
    a_first_byte: assert property (p_first_byte) else $error("first byte reloaded");

    property p_gate_hold;
        @(posedge core_clk) disable iff (!arst_n)
        gated_mode && !gate && clk_fall && !load_now && !ctrl_load |=> $stable(ce);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("counted with gate low");

    property p_hw_strobe;
        @(posedge core_clk) disable iff (!arst_n)
        mode == MODE_HW_STROBE && clk_fall && count_ok && !load_now && armed
            && dec_ce == CE_ZERO && !ctrl_load |=> !out_q && !armed;
    endproperty
    a_hw_strobe: assert property (p_hw_strobe) else $error("hardware strobe missing");

    property p_trig_latch;
        @(posedge core_clk) disable iff (!arst_n)
        (mode == MODE_HW_STROBE || mode == MODE_ONESHOT) && gate_rise && !ctrl_load
            |=> trig_pend;
    endproperty
    a_trig_latch: assert property (p_trig_latch) else $error("trigger lost");

    property p_hw_write_waits;
        @(posedge core_clk) disable iff (!arst_n)
        mode == MODE_HW_STROBE && ifc.count_done && !load_pend |=> !load_pend;
    endproperty
    a_hw_write_waits: assert property (p_hw_write_waits) else $error("write disturbed");

    property p_gate_forces_high;
        @(posedge core_clk) disable iff (!arst_n)
        periodic && !gate && !ctrl_load |=> out_q;
    endproperty
    a_gate_forces_high: assert property (p_gate_forces_high) else $error("gate low, out low");

    property p_square_step;
        @(posedge core_clk) disable iff (!arst_n)
        mode == MODE_SQUARE && clk_fall && count_ok && !load_now && !sq_term && !ctrl_load
            |=> ce == $past(ce) - STEP_TWO;
    endproperty
    a_square_step: assert property (p_square_step) else $error("square step not two");
endmodule

//--- core/timer_chan_pkg.sv
package timer_chan_pkg;

    // Counting modes; codes 6 and 7 fold onto 2 and 3 at the control word
    typedef enum logic [2:0] {
        MODE_EVENT     = 3'b000,
        MODE_ONESHOT   = 3'b001,
        MODE_RATE      = 3'b010,
        MODE_SQUARE    = 3'b011,
        MODE_SW_STROBE = 3'b100,
        MODE_HW_STROBE = 3'b101
    } mode_t;

    // Byte access selection of the control word
    typedef enum logic [1:0] {
        RW_LATCH = 2'b00,
        RW_LSB   = 2'b01,
        RW_MSB   = 2'b10,
        RW_BOTH  = 2'b11
    } rw_t;

    localparam mode_t       MODE_RESET = MODE_SW_STROBE;
    localparam rw_t         RW_RESET   = RW_LSB;
    localparam logic [15:0] CE_RESET   = 16'h0000;
    localparam logic [15:0] HOLD_RESET = 16'h0000;
    localparam logic        OUT_RESET  = 1'b1;
    localparam logic [15:0] STEP_ONE   = 16'h0001;
    localparam logic [15:0] STEP_TWO   = 16'h0002;
    localparam logic [15:0] CE_ZERO    = 16'h0000;
    localparam logic [15:0] RATE_END   = 16'h0001;
    localparam logic [15:0] SQUARE_END = 16'h0002;
    localparam logic [7:0]  BYTE_RESET = 8'h00;

    // Square wave loads an even value; odd counts drop their low bit
    function automatic logic [15:0] load_value(input logic [15:0] cnt, input mode_t md);
        load_value = (md == MODE_SQUARE) ? {cnt[15:1], 1'b0} : cnt;
    endfunction

endpackage

//--- core/chan_if.sv
`timescale 1ns/1ps
interface chan_if;
    import timer_chan_pkg::*;

    logic [15:0] held_cnt;
    logic        count_done;
    logic        first_done;
    logic [15:0] ce;
    logic        out_lvl;
    logic        null_count;
    mode_t       mode;
    rw_t         rw;
    logic        ctrl_load;
    logic        latch_req;

    modport host_side (
        output held_cnt, count_done, first_done,
        input  ce, out_lvl, null_count, mode, rw, ctrl_load, latch_req
    );
    modport core_side (
        input  held_cnt, count_done, first_done,
        output ce, out_lvl, null_count, mode, rw, ctrl_load, latch_req
    );
endinterface

//--- core/pin_edges.sv
`timescale 1ns/1ps
module pin_edges (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic arst_n,
    // Counter pins
    input  wire logic cnt_clk,
    input  wire logic gate,
    // Events
    output logic      clk_fall,
    output logic      gate_rise
);
    logic prev_clk;
    logic prev_gate;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_clk  <= 1'b0;
            // A gate held high through reset must not look like a rising edge
            prev_gate <= 1'b1;
        end else begin
            prev_clk  <= cnt_clk;
            prev_gate <= gate;
        end
    end

    assign clk_fall  = prev_clk & ~cnt_clk;
    assign gate_rise = ~prev_gate & gate;
endmodule

//--- core/host_byte_port.sv
`timescale 1ns/1ps
module host_byte_port
    import timer_chan_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    // Host bytes
    input  wire logic       wr_stb,
    input  wire logic [7:0] wr_data,
    input  wire logic       rd_stb,
    input  wire logic       rb_status,
    output logic      [7:0] rd_data,
    // Channel core
    chan_if.host_side       ifc
);
    logic [15:0] count_holding_register;
    logic [15:0] output_snapshot_latch;
    logic [7:0]  lsb_hold;
    logic [7:0]  status_byte;
    logic        wr_msb;
    logic        rd_msb;
    logic        snap_valid;
    logic        status_valid;

    wire [15:0] rd_src     = snap_valid ? output_snapshot_latch : ifc.ce;
    wire        rd_last    = (ifc.rw != RW_BOTH) || rd_msb;
    wire        rd_count   = rd_stb && !status_valid;
    wire        rd_hi_byte = (ifc.rw == RW_MSB) || (ifc.rw == RW_BOTH && rd_msb);
    wire        wr_first   = wr_stb && ifc.rw == RW_BOTH && !wr_msb;

    assign ifc.held_cnt = count_holding_register;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_holding_register <= HOLD_RESET;
            lsb_hold               <= BYTE_RESET;
            wr_msb                 <= 1'b0;
            ifc.count_done         <= 1'b0;
            ifc.first_done         <= 1'b0;
        end else begin
            ifc.count_done <= wr_stb && !wr_first && !ifc.ctrl_load;
            ifc.first_done <= wr_first && !ifc.ctrl_load;
            if (ifc.ctrl_load) begin
                wr_msb <= 1'b0;
            end else if (wr_first) begin
                lsb_hold <= wr_data;
                wr_msb   <= 1'b1;
            end else if (wr_stb) begin
                wr_msb <= 1'b0;
                case (ifc.rw)
                    RW_MSB:  count_holding_register <= {wr_data, BYTE_RESET};
                    RW_BOTH: count_holding_register <= {wr_data, lsb_hold};
                    default: count_holding_register <= {BYTE_RESET, wr_data};
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            output_snapshot_latch <= CE_RESET;
            snap_valid            <= 1'b0;
            rd_msb                <= 1'b0;
            rd_data               <= BYTE_RESET;
        end else begin
            if (rd_count) begin
                rd_data <= rd_hi_byte ? rd_src[15:8] : rd_src[7:0];
                rd_msb  <= (ifc.rw == RW_BOTH) && !rd_msb;
                if (rd_last) begin
                    snap_valid <= 1'b0;
                end
            end else if (rd_stb) begin
                rd_data <= status_byte;
            end
            if (ifc.ctrl_load) begin
                snap_valid <= 1'b0;
                rd_msb     <= 1'b0;
            end
            if (ifc.latch_req && !snap_valid) begin
                output_snapshot_latch <= ifc.ce;
                snap_valid            <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_byte  <= BYTE_RESET;
            status_valid <= 1'b0;
        end else begin
            if (rd_stb || ifc.ctrl_load) begin
                status_valid <= 1'b0;
            end
            if (rb_status && !status_valid) begin
                status_byte  <= {ifc.out_lvl, ifc.null_count, ifc.rw, ifc.mode, 1'b0};
                status_valid <= 1'b1;
            end
        end
    end

    property p_latch_hold;
        @(posedge core_clk) disable iff (!arst_n)
        snap_valid && !rd_count && !ifc.ctrl_load |=> snap_valid && $stable(output_snapshot_latch);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched count moved");

    property p_latch_take;
        @(posedge core_clk) disable iff (!arst_n)
        ifc.latch_req && !snap_valid |=> snap_valid && output_snapshot_latch == $past(ifc.ce);
    endproperty
    a_latch_take: assert property (p_latch_take) else $error("latch missed count");
endmodule

//--- tb/host_model.sv
`timescale 1ns/1ps
module host_model (
    // Clock
    input  wire logic       core_clk,
    // Host bus
    output logic            ctrl_wr,
    output logic      [2:0] ctrl_mode,
    output logic      [1:0] ctrl_rw,
    output logic            wr_stb,
    output logic      [7:0] wr_data,
    output logic            rd_stb,
    input  wire logic [7:0] rd_data
);
    initial begin
        ctrl_wr = 1'b0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        ctrl_mode = 3'h0;
        ctrl_rw = 2'h0;
        wr_data = 8'h00;
    end

    // Strobes last one cycle and change just after the rising edge
    task automatic ctrl(input logic [2:0] m, input logic [1:0] rw);
        @(posedge core_clk) #1;
        ctrl_wr = 1'b1;
        ctrl_mode = m;
        ctrl_rw = rw;
        @(posedge core_clk) #1;
        ctrl_wr = 1'b0;
    endtask

    task automatic wr(input logic [7:0] d);
        @(posedge core_clk) #1;
        wr_stb = 1'b1;
        wr_data = d;
        @(posedge core_clk) #1;
        wr_stb = 1'b0;
        wr_data = ~d;
    endtask

    task automatic rd(output logic [7:0] d);
        @(posedge core_clk) #1;
        rd_stb = 1'b1;
        @(posedge core_clk) #1;
        rd_stb = 1'b0;
        d = rd_data;
    endtask
endmodule

//--- tb/interval_timer_strobe_modes_tb_top.sv
`timescale 1ns/1ps
module interval_timer_strobe_modes_tb_top;
    import timer_chan_pkg::*;
    logic       core_clk = 1'b0;
    logic       arst_n   = 1'b0;
    logic       cnt_clk  = 1'b1;
    logic       gate     = 1'b1;
    logic       rb_count  = 1'b0;
    logic       rb_status = 1'b0;
    logic       ctrl_wr, wr_stb, rd_stb, cnt_out;
    logic [2:0] ctrl_mode;
    logic [1:0] ctrl_rw;
    logic [7:0] wr_data, rd_data, b;
    int         err_total = 0;
    int         n_compared = 0;
    int         cyc = 0;
    int         n, m, f, l;

    always #20 core_clk = ~core_clk;

    host_model host (.core_clk(core_clk), .ctrl_wr(ctrl_wr), .ctrl_mode(ctrl_mode),
        .ctrl_rw(ctrl_rw), .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb),
        .rd_data(rd_data));

    interval_channel DUT (.core_clk(core_clk), .arst_n(arst_n), .ctrl_wr(ctrl_wr),
        .ctrl_mode(ctrl_mode), .ctrl_rw(ctrl_rw), .rb_count(rb_count), .rb_status(rb_status),
        .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb), .rd_data(rd_data),
        .cnt_clk(cnt_clk), .gate(gate), .cnt_out(cnt_out));

    function automatic int strobe_at(input int cnt);
        return cnt + 1;
    endfunction

    function automatic logic [7:0] sq_after(input int cnt, input int steps);
        return 8'(cnt - 2 * steps);
    endfunction

    function automatic logic [7:0] status_of(input logic o, input logic nc,
                                              input logic [1:0] rw, input logic [2:0] md);
        return {o, nc, rw, md, 1'b0};
    endfunction

    // One-cycle read-back pulse latching both count and status
    task automatic rb_latch();
        @(posedge core_clk) #1;
        rb_count = 1'b1;
        rb_status = 1'b1;
        @(posedge core_clk) #1;
        rb_count = 1'b0;
        rb_status = 1'b0;
    endtask

    task automatic stop_test();
        if (err_total == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic cmp_pos(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            err_total++;
            $display("Error %0t strobe period %0d, expected %0d", $time, got, exp);
        end
    endtask

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t read byte %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t output %b, expected %b", $time, got, exp);
        end
    endtask

    // Runs count clock periods; reports first period with output low and low periods
    task automatic run(input int cnt, output int first, output int lows);
        logic low;
        first = 0;
        lows = 0;
        for (int p = 1; p <= cnt; p++) begin
            low = 1'b0;
            cnt_clk = 1'b1;
            repeat (2) @(posedge core_clk) #1;
            cnt_clk = 1'b0;
            @(posedge core_clk) #1;
            repeat (2) begin
                @(posedge core_clk) #1;
                low = low | (cnt_out !== 1'b1);
            end
            if (low && first == 0)
                first = p;
            lows += int'(low);
        end
        cnt_clk = 1'b1;
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            stop_test();
        end
    end

    initial begin
        void'($urandom(32'h3FBF66D7));
        repeat (12) @(posedge core_clk);
        #1 arst_n = 1'b1;
        n = 3 + $urandom % 5;
        m = n + 1 + $urandom % 4;
        host.ctrl(MODE_SW_STROBE, RW_LSB);
        host.wr(8'(n));
        run(n + 3, f, l);
        cmp_pos(f, strobe_at(n));
        cmp_pos(l, 1);
        // Two-byte reload in mid-count
        host.ctrl(MODE_SW_STROBE, RW_BOTH);
        host.wr(8'h04);
        host.wr(8'h00);
        run(2, f, l);
        host.wr(8'(m));
        run(3, f, l);
        cmp_pos(f, 3);
        host.wr(8'h00);
        run(m + 3, f, l);
        cmp_pos(f, strobe_at(m));
        host.ctrl(MODE_SW_STROBE, RW_LSB);
        host.wr(8'(n));
        gate = 1'b0;
        run(n + 3, f, l);
        cmp_pos(l, 0);
        // Hardware strobe: no trigger, then trigger, new count and retrigger
        host.ctrl(MODE_HW_STROBE, RW_LSB);
        host.wr(8'(n));
        run(n + 3, f, l);
        cmp_pos(l, 0);
        gate = 1'b1;
        run(2, f, l);
        host.wr(8'(m));
        gate = 1'b0;
        run(1, f, l);
        gate = 1'b1;
        run(m + 3, f, l);
        cmp_pos(f, strobe_at(m));
        cmp_pos(l, 1);
        // Square wave steps by two; count clock held while reading
        host.ctrl(MODE_SQUARE, RW_BOTH);
        host.wr(8'h08);
        host.wr(8'h00);
        run(2, f, l);
        host.ctrl(3'h0, RW_LATCH);
        host.rd(b);
        cmp_byte(b, sq_after(8, 1));
        host.rd(b);
        cmp_byte(b, 8'h00);
        // High half of eight is four clocks counted from the load
        run(3, f, l);
        cmp_pos(f, 3);
        gate = 1'b0;
        repeat (2) @(posedge core_clk) #1;
        cmp_bit(cnt_out, 1'b1);
        // Rate generator through folded code 6: gate low blocks, rise reloads
        gate = 1'b1;
        host.ctrl(3'h6, RW_LSB);
        host.wr(8'(n));
        run(n - 1, f, l);
        gate = 1'b0;
        run(3, f, l);
        cmp_pos(l, 0);
        gate = 1'b1;
        run(n, f, l);
        cmp_pos(f, n);
        // One-shot waits for a gate rise, then stays low for n clocks
        host.ctrl(3'h1, RW_LSB);
        host.wr(8'(n));
        run(2, f, l);
        cmp_pos(l, 0);
        gate = 1'b0;
        @(posedge core_clk) #1;
        gate = 1'b1;
        run(n + 2, f, l);
        cmp_pos(f, 1);
        cmp_pos(l, n);
        // Event counting pauses on gate low; then status and count read back
        host.ctrl(3'h0, RW_LSB);
        host.wr(8'(n));
        run(1, f, l);
        gate = 1'b0;
        run(2, f, l);
        gate = 1'b1;
        run(n + 1, f, l);
        cmp_pos(l, n - 1);
        rb_latch();
        host.rd(b);
        cmp_byte(b, status_of(1'b1, 1'b0, RW_LSB, MODE_EVENT));
        host.rd(b);
        cmp_byte(b, 8'(n - (n + 1)));
        stop_test();
    end
endmodule
